// ===== fdrb_pkg.sv
// Shared constants and types for the decimating filter register bank
package fdrb_pkg;
    // ==========================================================
    // Bus geometry
    localparam int ADDR_W = 13;
    localparam int DATA_W = 32;
    localparam int TAP_ADDR_W = 10;
    localparam int TAP_COUNT = 1024;

    // ==========================================================
    // Register offsets
    localparam logic [12:0] OFF_RATE_CTRL = 13'h0000;
    localparam logic [12:0] OFF_OUTPUT_SCALE = 13'h0004;
    localparam logic [12:0] OFF_PATH_CTRL = 13'h0008;
    localparam logic [12:0] OFF_TAP_LOAD_CTRL = 13'h000C;
    localparam logic [12:0] OFF_TAP_LOAD_STATE = 13'h0010;
    localparam logic [12:0] OFF_IRQ_ENABLE = 13'h0014;
    localparam logic [12:0] OFF_IRQ_SOURCE_STATE = 13'h0018;
    localparam logic [12:0] OFF_IRQ_LATCHED_FLAGS = 13'h001C;
    localparam logic [12:0] OFF_TAP_WINDOW_BASE = 13'h1000;

    // ==========================================================
    // Field widths, positions and reset values
    localparam int RATE_W = 5;
    localparam int SCALE_W = 16;
    localparam logic [4:0] RATE_RESET = 5'h01;
    localparam logic [15:0] SCALE_RESET = 16'h0800;
    localparam int PATH_FILTER_BIT = 0;
    localparam int PATH_SYNC_BIT = 1;
    localparam int LOAD_BIT = 0;
    localparam int STATE_RUNNING_BIT = 0;
    localparam int STATE_COMPLETE_BIT = 1;
    localparam int IRQ_SAT_BIT = 0;

    // ==========================================================
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {
        FDRB_LOAD_IDLE,
        FDRB_LOAD_RUN
    } fdrb_load_state_t;
endpackage

// ===== fdrb_load_if.sv
// Link between the register bank and the coefficient transfer engine
interface fdrb_load_if;
    import fdrb_pkg::*;
    logic start;
    logic [TAP_ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    logic running;
    logic complete;

    modport engine (
        input start,
        input rd_data,
        output rd_addr,
        output running,
        output complete
    );
    modport bank (
        output start,
        output rd_data,
        input rd_addr,
        input running,
        input complete
    );
endinterface

// ===== fdrb_load_engine.sv
// Coefficient transfer engine: walks the tap memory into the active filter
module fdrb_load_engine
    import fdrb_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    fdrb_load_if.engine lif,
    output logic tap_load_strobe,
    output logic [TAP_ADDR_W-1:0] tap_load_addr,
    output logic [DATA_W-1:0] tap_load_data
);
    fdrb_load_state_t state, next_state;
    logic [TAP_ADDR_W-1:0] addr, next_addr;
    logic complete, next_complete;
    logic strobe, next_strobe;
    logic [TAP_ADDR_W-1:0] out_addr, next_out_addr;
    logic [DATA_W-1:0] out_data, next_out_data;

    // ==========================================================
    // Sequencer
    always_comb begin
        next_state = state;
        next_addr = addr;
        next_complete = complete;
        next_strobe = 1'b0;
        next_out_addr = out_addr;
        next_out_data = out_data;
        case (state)
            FDRB_LOAD_IDLE: begin
                if (lif.start) begin
                    next_state = FDRB_LOAD_RUN;
                    next_addr = '0;
                    next_complete = 1'b0;
                end
            end
            FDRB_LOAD_RUN: begin
                next_strobe = 1'b1;
                next_out_addr = addr;
                next_out_data = lif.rd_data;
                next_addr = addr + 1'b1;
                if (lif.start) begin
                    // A fresh request restarts the walk from tap zero
                    next_addr = '0;
                    next_strobe = 1'b0;
                end else if (addr == TAP_ADDR_W'(TAP_COUNT - 1)) begin
                    next_state = FDRB_LOAD_IDLE;
                    next_complete = 1'b1;
                end
            end
            default: begin
                next_state = FDRB_LOAD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= FDRB_LOAD_IDLE;
            addr <= '0;
            complete <= 1'b0;
            strobe <= 1'b0;
            out_addr <= '0;
            out_data <= '0;
        end else begin
            state <= next_state;
            addr <= next_addr;
            complete <= next_complete;
            strobe <= next_strobe;
            out_addr <= next_out_addr;
            out_data <= next_out_data;
        end
    end

    assign lif.rd_addr = addr;
    assign lif.running = (state == FDRB_LOAD_RUN);
    assign lif.complete = complete;
    assign tap_load_strobe = strobe;
    assign tap_load_addr = out_addr;
    assign tap_load_data = out_data;
endmodule

// ===== fdrb_register_bank.sv
// Register bank of the decimating filter core, reached over AXI4-Lite
module fdrb_register_bank
    import fdrb_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sat_detect,
    input wire logic sync_marker,
    output logic [RATE_W-1:0] decim_value,
    output logic [RATE_W:0] decim_factor,
    output logic [RATE_W-1:0] decim_phase,
    output logic decim_tick,
    output logic [SCALE_W-1:0] gain_value,
    output logic filter_enable,
    output logic sync_enable,
    output logic sat,
    output logic irq,
    output logic tap_load_strobe,
    output logic [TAP_ADDR_W-1:0] tap_load_addr,
    output logic [DATA_W-1:0] tap_load_data,
    output logic tap_load_running,
    output logic tap_load_complete
);
    fdrb_load_if lif ();

    logic [RATE_W-1:0] rate, next_rate;
    logic [SCALE_W-1:0] scale, next_scale;
    logic [1:0] path, next_path;
    logic load_bit, next_load_bit;
    logic irq_en, next_irq_en;
    logic src, next_src;
    logic flag, next_flag;
    logic irq_q, next_irq_q;
    logic [RATE_W-1:0] phase, next_phase;
    logic tick, next_tick;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [1:0] rresp, next_rresp;
    logic [DATA_W-1:0] rdata, next_rdata;
    logic [DATA_W-1:0] tap_mem [TAP_COUNT];
    logic wr_go, rd_go, wr_win, rd_win;
    logic [TAP_ADDR_W-1:0] wr_idx, rd_idx;

    // ==========================================================
    // Write and read acceptance
    // Address and data are taken together so no skid storage is needed
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid;
    assign rd_go = s_axi_arvalid && !rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;
    assign wr_win = s_axi_awaddr[12];
    assign rd_win = s_axi_araddr[12];
    assign wr_idx = s_axi_awaddr[TAP_ADDR_W+1:2];
    assign rd_idx = s_axi_araddr[TAP_ADDR_W+1:2];

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] val,
                                                input logic [3:0] strb);
        logic [DATA_W-1:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = val[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ==========================================================
    // Tap memory window
    always_ff @(posedge clk) begin
        if (wr_go && wr_win) begin
            tap_mem[wr_idx] <= merge(tap_mem[wr_idx], s_axi_wdata, s_axi_wstrb);
        end
    end
    assign lif.rd_data = tap_mem[lif.rd_addr];

    // ==========================================================
    // Register writes, events and read mux
    always_comb begin
        logic [DATA_W-1:0] w;
        logic [12:0] wa;
        logic [12:0] ra;
        w = '0;
        wa = {s_axi_awaddr[12:2], 2'b00};
        ra = {s_axi_araddr[12:2], 2'b00};
        next_rate = rate;
        next_scale = scale;
        next_path = path;
        next_load_bit = load_bit;
        next_irq_en = irq_en;
        next_bvalid = bvalid && !s_axi_bready;
        next_bresp = bresp;
        next_rvalid = rvalid && !s_axi_rready;
        next_rresp = rresp;
        next_rdata = rdata;
        next_src = sat_detect && path[PATH_FILTER_BIT];
        next_flag = flag;
        if (wr_go) begin
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            if (!wr_win) begin
                case (wa)
                    OFF_RATE_CTRL: begin
                        w = merge({27'h0, rate}, s_axi_wdata, s_axi_wstrb);
                        next_rate = w[RATE_W-1:0];
                    end
                    OFF_OUTPUT_SCALE: begin
                        w = merge({16'h0, scale}, s_axi_wdata, s_axi_wstrb);
                        next_scale = w[SCALE_W-1:0];
                    end
                    OFF_PATH_CTRL: begin
                        w = merge({30'h0, path}, s_axi_wdata, s_axi_wstrb);
                        next_path = w[1:0];
                    end
                    OFF_TAP_LOAD_CTRL: begin
                        w = merge({31'h0, load_bit}, s_axi_wdata, s_axi_wstrb);
                        next_load_bit = w[LOAD_BIT];
                    end
                    OFF_IRQ_ENABLE: begin
                        w = merge({31'h0, irq_en}, s_axi_wdata, s_axi_wstrb);
                        next_irq_en = w[IRQ_SAT_BIT];
                    end
                    OFF_IRQ_LATCHED_FLAGS: begin
                        // Write one to clear, only on the selected bit
                        if (s_axi_wstrb[0] && s_axi_wdata[IRQ_SAT_BIT]) begin
                            next_flag = 1'b0;
                        end
                    end
                    OFF_TAP_LOAD_STATE, OFF_IRQ_SOURCE_STATE: begin
                        next_bresp = RESP_OKAY;
                    end
                    default: begin
                        next_bresp = RESP_SLVERR;
                    end
                endcase
            end
        end
        // Set wins over a clear in the same cycle
        if (next_src && !src) begin
            next_flag = 1'b1;
        end
        next_irq_q = next_src && !src && irq_en;
        if (rd_go) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = '0;
            if (rd_win) begin
                next_rdata = tap_mem[rd_idx];
            end else begin
                case (ra)
                    OFF_RATE_CTRL: next_rdata = {27'h0, rate};
                    OFF_OUTPUT_SCALE: next_rdata = {16'h0, scale};
                    OFF_PATH_CTRL: next_rdata = {30'h0, path};
                    OFF_TAP_LOAD_CTRL: next_rdata = {31'h0, load_bit};
                    OFF_TAP_LOAD_STATE: next_rdata = {30'h0, lif.complete, lif.running};
                    OFF_IRQ_ENABLE: next_rdata = {31'h0, irq_en};
                    OFF_IRQ_SOURCE_STATE: next_rdata = {31'h0, src};
                    OFF_IRQ_LATCHED_FLAGS: next_rdata = {31'h0, flag};
                    default: next_rresp = RESP_SLVERR;
                endcase
            end
        end
    end

    // ==========================================================
    // Decimation counter
    always_comb begin
        next_tick = 1'b0;
        next_phase = phase + 1'b1;
        if (sync_marker && path[PATH_SYNC_BIT]) begin
            next_phase = '0;
        end else if (phase >= rate) begin
            next_phase = '0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rate <= RATE_RESET;
            scale <= SCALE_RESET;
            path <= 2'h0;
            load_bit <= 1'b0;
            irq_en <= 1'b0;
            src <= 1'b0;
            flag <= 1'b0;
            irq_q <= 1'b0;
            phase <= '0;
            tick <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= '0;
            sat <= 1'b0;
        end else begin
            rate <= next_rate;
            scale <= next_scale;
            path <= next_path;
            load_bit <= next_load_bit;
            irq_en <= next_irq_en;
            src <= next_src;
            flag <= next_flag;
            irq_q <= next_irq_q;
            phase <= next_phase;
            tick <= next_tick;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            sat <= sat_detect;
        end
    end

    // Falling load bit after a one starts the walk
    assign lif.start = load_bit && !next_load_bit;

    fdrb_load_engine u_engine (
        .clk(clk),
        .srst(srst),
        .lif(lif),
        .tap_load_strobe(tap_load_strobe),
        .tap_load_addr(tap_load_addr),
        .tap_load_data(tap_load_data)
    );

    // ==========================================================
    // Outputs to the bus, the datapath and the interrupt line
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rresp = rresp;
    assign s_axi_rdata = rdata;
    assign decim_value = rate;
    assign decim_factor = {1'b0, rate} + 6'h01;
    assign decim_phase = phase;
    assign decim_tick = tick;
    assign gain_value = scale;
    assign filter_enable = path[PATH_FILTER_BIT];
    assign sync_enable = path[PATH_SYNC_BIT];
    assign irq = irq_q;
    assign tap_load_running = lif.running;
    assign tap_load_complete = lif.complete;
endmodule

// ===== fdrb_register_bank_sva.sv
// Port checker for the decimating filter register bank
module fdrb_register_bank_sva
    import fdrb_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic sat_detect,
    input wire logic sync_marker,
    input wire logic [RATE_W-1:0] decim_value,
    input wire logic [RATE_W:0] decim_factor,
    input wire logic [RATE_W-1:0] decim_phase,
    input wire logic decim_tick,
    input wire logic filter_enable,
    input wire logic sync_enable,
    input wire logic sat,
    input wire logic irq,
    input wire logic tap_load_strobe,
    input wire logic [TAP_ADDR_W-1:0] tap_load_addr,
    input wire logic tap_load_running,
    input wire logic tap_load_complete
);
    // ====================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    rate_plus_one_a: assert property (
        decim_factor == {1'h0, decim_value} + 6'h01) else $error("factor not rate plus one");
    phase_wrap_a: assert property (
        decim_phase >= decim_value && !(sync_enable && sync_marker)
        |=> decim_phase == 5'h00 && decim_tick) else $error("phase did not wrap");
    sync_clear_a: assert property (
        sync_enable && sync_marker |=> decim_phase == 5'h00 && !decim_tick)
        else $error("sync did not clear phase");
    sync_ignore_a: assert property (
        sync_marker && !sync_enable && decim_phase < decim_value
        |=> decim_phase == $past(decim_phase) + 5'h01) else $error("sync not ignored");
    sat_follow_a: assert property (
        !$past(srst) |-> sat == $past(sat_detect)) else $error("sat not delayed input");
    irq_cause_a: assert property (
        irq |-> $past(sat_detect) && $past(filter_enable) && !$past(irq))
        else $error("irq without rising source");
    load_first_a: assert property (
        $rose(tap_load_running) |=> tap_load_strobe && tap_load_addr == 10'h000)
        else $error("load did not start at tap zero");
    load_step_a: assert property (
        tap_load_strobe && tap_load_addr != 10'h3FF
        |=> tap_load_strobe && tap_load_addr == $past(tap_load_addr) + 10'h001)
        else $error("tap sequence broken");
    load_done_a: assert property (
        tap_load_strobe && tap_load_addr == 10'h3FF |-> tap_load_complete && !tap_load_running)
        else $error("last tap without completion");
    cover property (irq);
    cover property ($rose(tap_load_complete));
    cover property (sync_enable && sync_marker);
endmodule

bind fdrb_register_bank fdrb_register_bank_sva u_sva (.*);

// ===== tb_fir_decimator_register_bank.sv
// Self-checking testbench for the decimating filter register bank
module tb_fir_decimator_register_bank import fdrb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, srst = 1'h1;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, tap_load_data;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, sat_detect = 1'h0, sync_marker = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [RATE_W-1:0] decim_value, decim_phase;
    logic [RATE_W:0] decim_factor;
    logic [SCALE_W-1:0] gain_value;
    logic [TAP_ADDR_W-1:0] tap_load_addr;
    logic decim_tick, filter_enable, sync_enable, sat, irq;
    logic tap_load_strobe, tap_load_running, tap_load_complete;
    int num_errors = 0, compares = 0;

    fdrb_register_bank dut (.*);

    always #5 clk = ~clk;

    // ====================
    // Shared tasks
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task close_out();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Called at a falling edge; bready stays high so bvalid lasts one cycle
    task wr(input logic [12:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        s_axi_awaddr = a;
        s_axi_wdata = d;
        s_axi_wstrb = s;
        s_axi_awvalid = 1'h1;
        s_axi_wvalid = 1'h1;
        do begin
            @(posedge clk);
        end while (s_axi_awready !== 1'h1);
        @(negedge clk);
        s_axi_awvalid = 1'h0;
        s_axi_wvalid = 1'h0;
        chk(s_axi_bvalid, 1'h1);
        chk(s_axi_bresp, r);
        // Idle cycle so valid never drops and rises in one step
        @(negedge clk);
    endtask

    task rd(input logic [12:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_araddr = a;
        s_axi_arvalid = 1'h1;
        do begin
            @(posedge clk);
        end while (s_axi_arready !== 1'h1);
        @(negedge clk);
        s_axi_arvalid = 1'h0;
        chk(s_axi_rvalid, 1'h1);
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, r);
        @(negedge clk);
    endtask

    // ====================
    // Scenarios
    task t_reset();
        for (int i = 0; i < 8; i++) begin
            rd(13'(i * 4), i == 0 ? 32'h1 : (i == 1 ? 32'h800 : 32'h0), RESP_OKAY);
        end
    endtask

    task t_fields();
        wr(OFF_RATE_CTRL, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
        rd(OFF_RATE_CTRL, 32'h0000_001F, RESP_OKAY);
        wr(OFF_OUTPUT_SCALE, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
        wr(OFF_OUTPUT_SCALE, 32'h0000_1234, 4'h1, RESP_OKAY);
        rd(OFF_OUTPUT_SCALE, 32'h0000_FF34, RESP_OKAY);
        chk(gain_value, 32'h0000_FF34);
        wr(OFF_PATH_CTRL, 32'h0000_0001, 4'hF, RESP_OKAY);
        chk(filter_enable, 1'h1);
        wr(OFF_TAP_LOAD_STATE, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
        rd(OFF_TAP_LOAD_STATE, 32'h0, RESP_OKAY);
        wr(13'h0020, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
        rd(13'h0020, 32'h0, RESP_SLVERR);
    endtask

    // Exactly four rate periods always hold four ticks
    task t_decim(input logic [4:0] r);
        int n;
        n = 0;
        wr(OFF_RATE_CTRL, {27'h0, r}, 4'h1, RESP_OKAY);
        chk(decim_factor, r + 6'h01);
        chk(decim_value, {27'h0, r});
        repeat ((r + 1) * 4) begin
            @(negedge clk);
            n += decim_tick;
        end
        chk(n, 4);
    endtask

    // Expects the rate left at 31 by the preceding scenario
    task t_sync(input logic en);
        logic [4:0] p;
        wr(OFF_PATH_CTRL, {30'h0, en, 1'h0}, 4'h1, RESP_OKAY);
        chk(sync_enable, en);
        p = decim_phase;
        sync_marker = 1'h1;
        @(negedge clk);
        sync_marker = 1'h0;
        chk(decim_phase, (en || p == 5'h1F) ? 5'h00 : p + 5'h01);
    endtask

    task t_load();
        int n;
        n = 0;
        wr(OFF_TAP_WINDOW_BASE, 32'hA5A5_0001, 4'hF, RESP_OKAY);
        wr(13'h1FFC, 32'h5A5A_03FF, 4'hF, RESP_OKAY);
        rd(13'h1FFC, 32'h5A5A_03FF, RESP_OKAY);
        wr(OFF_TAP_LOAD_CTRL, 32'h1, 4'h1, RESP_OKAY);
        chk(tap_load_running, 1'h0);
        wr(OFF_TAP_LOAD_CTRL, 32'h0, 4'h1, RESP_OKAY);
        chk(tap_load_running, 1'h1);
        // First strobe already stands on return, so sample before waiting
        repeat (1100) begin
            if (tap_load_strobe === 1'h1) begin
                n++;
                if (tap_load_addr === 10'h000) chk(tap_load_data, 32'hA5A5_0001);
                if (tap_load_addr === 10'h3FF) chk(tap_load_data, 32'h5A5A_03FF);
            end
            @(negedge clk);
        end
        chk(n, 1024);
        chk(tap_load_complete, 1'h1);
        rd(OFF_TAP_LOAD_STATE, 32'h2, RESP_OKAY);
    endtask

    task sat_burst(input int exp_irq);
        int n;
        n = 0;
        sat_detect = 1'h1;
        repeat (4) begin
            @(negedge clk);
            n += irq;
        end
        chk(sat, 1'h1);
        rd(OFF_IRQ_SOURCE_STATE, 32'h1, RESP_OKAY);
        sat_detect = 1'h0;
        repeat (4) begin
            @(negedge clk);
            n += irq;
        end
        chk(n, exp_irq);
        chk(sat, 1'h0);
    endtask

    task t_irq();
        wr(OFF_PATH_CTRL, 32'h1, 4'h1, RESP_OKAY);
        wr(OFF_IRQ_ENABLE, 32'h1, 4'h1, RESP_OKAY);
        sat_burst(1);
        rd(OFF_IRQ_SOURCE_STATE, 32'h0, RESP_OKAY);
        rd(OFF_IRQ_LATCHED_FLAGS, 32'h1, RESP_OKAY);
        wr(OFF_IRQ_LATCHED_FLAGS, 32'h1, 4'h2, RESP_OKAY);
        rd(OFF_IRQ_LATCHED_FLAGS, 32'h1, RESP_OKAY);
        wr(OFF_IRQ_LATCHED_FLAGS, 32'h1, 4'h1, RESP_OKAY);
        rd(OFF_IRQ_LATCHED_FLAGS, 32'h0, RESP_OKAY);
        wr(OFF_IRQ_ENABLE, 32'h0, 4'h1, RESP_OKAY);
        sat_burst(0);
        rd(OFF_IRQ_LATCHED_FLAGS, 32'h1, RESP_OKAY);
    endtask

    // ====================
    // Main sequence and watchdog
    initial begin
        repeat (2) @(negedge clk);
        srst = 1'h0;
        t_reset();
        t_fields();
        t_decim(5'h01);
        t_decim(5'h03);
        t_decim(5'h1F);
        t_sync(1'h1);
        t_sync(1'h0);
        t_load();
        t_irq();
        close_out();
    end

    // Whole run needs about 1,400 cycles
    initial begin
        #100us;
        num_errors++;
        close_out();
    end
endmodule
